// ### src/csso_pkg.sv
/*
  Constants for the channel select and strap observe block of a two-channel
  retimer. Assumes one 40 MHz clock and a byte-wide register access port.
*/
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------
// What this block does
// - Select bit 5 picks loss or interrupt pin
// - Select bit 3 broadcasts channel writes to both
// - Channel reads use only the targeted channel
// - Select bit 2 steers shared versus channel set
// - Select bits 1:0 name target channel, reset 0
// - Observation code shows strap in shared 0x00[7:4]
// - Strap nibble equals pin level sampled just after each reset release
// - Strap zero answers write address 0x30
// - Address channel_access_select always targets the shared set
// - Shared 0x05 bits 3:2 flag channel interrupts
package csso_pkg;
  // ------------------------------------------------------------
  // Offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STRAP_OBS   = 8'h00;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h05;
  localparam logic [7:0] OFS_DIAG_CTRL   = 8'h06;
  localparam logic [7:0] OFS_CHAN_SELECT = 8'hFF;
  // ------------------------------------------------------------
  // Fields
  // ------------------------------------------------------------
  localparam int SEL_PIN_FUNC_BIT  = 5;
  localparam int SEL_BROADCAST_BIT = 3;
  localparam int SEL_CHAN_EN_BIT   = 2;
  localparam int SEL_TARGET_LSB    = 0;
  localparam int IRQ_A_BIT         = 3;
  localparam int IRQ_B_BIT         = 2;
  localparam int STRAP_OBS_LSB     = 4;
  localparam logic [3:0] DIAG_OBSERVE_CODE = 4'hA;
  localparam logic [1:0] TARGET_CHAN_A     = 2'h0;
  localparam logic [1:0] TARGET_CHAN_B     = 2'h1;
  // ------------------------------------------------------------
  // Reset values and addressing
  // ------------------------------------------------------------
  localparam logic [7:0] SELECT_RESET    = 8'h00;
  localparam logic [7:0] DIAG_RESET      = 8'h00;
  localparam logic [6:0] BASE_SLAVE_ADDR = 7'h18;
  localparam int         STRAP_SETTLE    = 3;
endpackage

// ### src/csso_strap_capture.sv
/*
  Strap capture: synchronises the address strap pins and latches them once
  shortly after reset release. Assumes pins are static around power-up.
*/
`timescale 1ns/1ps
module csso_strap_capture #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Pins and capture
  input  wire logic [WIDTH-1:0] strap_pin,
  output logic      [WIDTH-1:0] strap_value,
  output logic                  strap_done
);
  import csso_pkg::*;
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [1:0]       settle;
  logic [1:0]       next_settle;
  logic [WIDTH-1:0] next_strap_value;
  logic             next_strap_done;

  always_comb begin
    next_settle      = settle;
    next_strap_value = strap_value;
    next_strap_done  = strap_done;
    if (!strap_done) begin
      if (settle == 2'(STRAP_SETTLE - 1)) begin
        next_strap_value = sync2;
        next_strap_done  = 1'b1;
      end else begin
        next_settle = settle + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    sync1 <= strap_pin;
    sync2 <= sync1;
    if (!rst_b) begin
      settle      <= 2'h0;
      strap_value <= '0;
      strap_done  <= 1'b0;
    end else begin
      settle      <= next_settle;
      strap_value <= next_strap_value;
      strap_done  <= next_strap_done;
    end
  end
endmodule // csso_strap_capture

// ### src/csso_channel_select.sv
/*
  Register access steering for a two-channel retimer: holds the channel
  select and diagnostic control registers, routes writes, muxes reads.
  Assumes an SMBus serial engine on the same clock delivering byte accesses.
*/
`timescale 1ns/1ps
module csso_channel_select (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Access from serial engine
  input  wire logic [6:0] acc_slave_addr,
  input  wire logic       acc_wr,
  input  wire logic       acc_rd,
  input  wire logic [7:0] acc_addr,
  input  wire logic [7:0] acc_wdata,
  output logic      [7:0] acc_rdata,
  output logic            acc_rvalid,
  output logic      [6:0] own_slave_addr,
  // Register set write ports
  output logic            shared_wr,
  output logic            chan_a_wr,
  output logic            chan_b_wr,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  // Register set read data, combinational on acc_addr
  input  wire logic [7:0] shared_rdata,
  input  wire logic [7:0] chan_a_rdata,
  input  wire logic [7:0] chan_b_rdata,
  // Channel status
  input  wire logic       chan_a_irq,
  input  wire logic       chan_b_irq,
  input  wire logic       chan_a_loss,
  input  wire logic       chan_b_loss,
  // Pins
  input  wire logic [3:0] strap_pin,
  output logic            signal_loss_or_irq_pin
);
  import csso_pkg::*;

  logic [7:0] chan_select;
  logic [7:0] diag_ctrl;
  logic [7:0] next_chan_select;
  logic [7:0] next_diag_ctrl;
  logic [7:0] next_rdata;
  logic       next_shared_wr;
  logic       next_a_wr;
  logic       next_b_wr;
  logic       next_pin;
  logic       hit;
  logic       to_chan;
  logic [3:0] strap_value;
  logic       strap_done;

  csso_strap_capture #(.WIDTH(4)) u_strap (
    .clk         (clk),
    .rst_b       (rst_b),
    .strap_pin   (strap_pin),
    .strap_value (strap_value),
    .strap_done  (strap_done)
  );

  // ------------------------------------------------------------
  // Steering
  // ------------------------------------------------------------
  always_comb begin
    hit = (acc_slave_addr == own_slave_addr) && strap_done;
    // enable steers set; channel_access_select never a channel; strap_done gates all
    to_chan = chan_select[SEL_CHAN_EN_BIT] && (acc_addr != OFS_CHAN_SELECT);
  end

  always_comb begin
    next_chan_select = chan_select;
    next_diag_ctrl   = diag_ctrl;
    next_shared_wr   = 1'b0;
    next_a_wr        = 1'b0;
    next_b_wr        = 1'b0;
    next_rdata       = acc_rdata;
    if (hit && acc_wr) begin
      if (to_chan) begin
        // broadcast to both; else target only
        next_a_wr = chan_select[SEL_BROADCAST_BIT] ||
                    (chan_select[1:0] == TARGET_CHAN_A);
        next_b_wr = chan_select[SEL_BROADCAST_BIT] ||
                    (chan_select[1:0] == TARGET_CHAN_B);
      end else begin
        next_shared_wr = 1'b1;
        if (acc_addr == OFS_CHAN_SELECT)
          next_chan_select = acc_wdata;
        if (acc_addr == OFS_DIAG_CTRL)
          next_diag_ctrl = acc_wdata;
      end
    end
    if (hit && acc_rd) begin
      if (to_chan) begin
        case (chan_select[1:0])
          TARGET_CHAN_A: next_rdata = chan_a_rdata;
          TARGET_CHAN_B: next_rdata = chan_b_rdata;
          default:       next_rdata = 8'h00;
        endcase
      end else begin
        case (acc_addr)
          OFS_CHAN_SELECT: next_rdata = chan_select;
          OFS_DIAG_CTRL:   next_rdata = diag_ctrl;
          OFS_IRQ_FLAGS: begin
            next_rdata = shared_rdata;
            next_rdata[IRQ_A_BIT] = chan_a_irq;
            next_rdata[IRQ_B_BIT] = chan_b_irq;
          end
          OFS_STRAP_OBS: begin
            next_rdata = shared_rdata;
            // strap shown under code; host sets code first
            if (diag_ctrl[3:0] == DIAG_OBSERVE_CODE)
              next_rdata[7:STRAP_OBS_LSB] = strap_value;
          end
          default:         next_rdata = shared_rdata;
        endcase
      end
    end
    if (chan_select[SEL_PIN_FUNC_BIT])
      next_pin = chan_a_irq | chan_b_irq;
    else
      next_pin = chan_a_loss | chan_b_loss;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chan_select            <= SELECT_RESET;
      diag_ctrl              <= DIAG_RESET;
      acc_rdata              <= 8'h00;
      acc_rvalid             <= 1'b0;
      shared_wr              <= 1'b0;
      chan_a_wr              <= 1'b0;
      chan_b_wr              <= 1'b0;
      wr_addr                <= 8'h00;
      wr_data                <= 8'h00;
      signal_loss_or_irq_pin <= 1'b0;
      own_slave_addr         <= BASE_SLAVE_ADDR;
    end else begin
      chan_select            <= next_chan_select;
      diag_ctrl              <= next_diag_ctrl;
      acc_rdata              <= next_rdata;
      acc_rvalid             <= hit && acc_rd;
      shared_wr              <= next_shared_wr;
      chan_a_wr              <= next_a_wr;
      chan_b_wr              <= next_b_wr;
      wr_addr                <= acc_addr;
      wr_data                <= acc_wdata;
      signal_loss_or_irq_pin <= next_pin;
      // Strap zero gives 8-bit write address 0x30
      own_slave_addr         <= BASE_SLAVE_ADDR + {2'h0, strap_value, 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_chan_wr;
    acc_wr && hit && chan_select[SEL_CHAN_EN_BIT] && acc_addr != OFS_CHAN_SELECT;
  endsequence

  a_pin_function: assert property (
    chan_select[SEL_PIN_FUNC_BIT] |=> signal_loss_or_irq_pin == $past(chan_a_irq | chan_b_irq))
    else $error("pin not showing interrupt");
  a_broadcast_write: assert property (
    s_chan_wr and chan_select[SEL_BROADCAST_BIT] |=> chan_a_wr && chan_b_wr && !shared_wr)
    else $error("broadcast write missed a channel");
  a_read_one_chan: assert property (
    acc_rd && hit && to_chan && chan_select[1:0] == TARGET_CHAN_B |=> acc_rdata == $past(chan_b_rdata))
    else $error("channel read from wrong set");
  a_shared_steer: assert property (
    acc_wr && hit && !chan_select[SEL_CHAN_EN_BIT] |=> shared_wr && !chan_a_wr && !chan_b_wr)
    else $error("write left shared set");
  a_target_only: assert property (
    s_chan_wr and !chan_select[SEL_BROADCAST_BIT] and chan_select[1:0] == TARGET_CHAN_A
      |=> chan_a_wr && !chan_b_wr)
    else $error("targeted write wrong channel");
  a_strap_observe: assert property (
    acc_rd && hit && !to_chan && acc_addr == OFS_STRAP_OBS && diag_ctrl[3:0] == DIAG_OBSERVE_CODE
      |=> acc_rdata[7:4] == strap_value)
    else $error("strap not shown");
  a_strap_stable: assert property (
    strap_done |=> $stable(strap_value))
    else $error("strap changed after capture");
  a_select_shared: assert property (
    acc_wr && hit && acc_addr == OFS_CHAN_SELECT |=> shared_wr && chan_select == $past(acc_wdata))
    else $error("select write misrouted");
  a_irq_flags: assert property (
    acc_rd && hit && !to_chan && acc_addr == OFS_IRQ_FLAGS
      |=> acc_rdata[3:2] == {$past(chan_a_irq), $past(chan_b_irq)})
    else $error("interrupt flags wrong");
  a_own_address: assert property (
    strap_done && strap_value == 4'h0 |=> own_slave_addr == 7'h18)
    else $error("strap zero address wrong");
endmodule // csso_channel_select

// ### dv/csso_host_model.sv
/*
  Host model: issues byte reads and writes on the access port.
  Assumes the bench drives clk and the slave address.
*/
`timescale 1ns/1ps
module csso_host_model (
  // Clock
  input  wire logic       clk,
  // Access port
  output logic            acc_wr,
  output logic            acc_rd,
  output logic      [7:0] acc_addr,
  output logic      [7:0] acc_wdata,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid
);
  initial begin
    acc_wr    = 1'b0;
    acc_rd    = 1'b0;
    acc_addr  = 8'h00;
    acc_wdata = 8'h00;
  end
  // ------------------------------------------------------------
  // Byte accesses
  // ------------------------------------------------------------
  // Idle lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    acc_wr    <= 1'b1;
    acc_addr  <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_wr    <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    acc_rd   <= 1'b1;
    acc_addr <= a;
    @(posedge clk);
    acc_rd   <= 1'b0;
    acc_addr <= ~a;
    #1;
    d = acc_rdata;
    v = acc_rvalid;
  endtask
endmodule // csso_host_model

// ### dv/channel_select_and_strap_observe_tb.sv
/*
  Bench for the channel select block: steering, pin function, flags,
  strap observation, refused accesses. Assumes the host model file.
*/
`timescale 1ns/1ps
module channel_select_and_strap_observe_tb;
  import csso_pkg::*;
  localparam logic [7:0] SH = 8'h96;
  localparam logic [7:0] CA = 8'hA1;
  localparam logic [7:0] CB = 8'hB2;
  logic       clk = 1'b0, rst_b = 1'b0, la = 1'b0, lb = 1'b0, ia = 1'b0, ib = 1'b0;
  logic       acc_wr, acc_rd, acc_rvalid, shared_wr, chan_a_wr, chan_b_wr, pin, vld;
  logic [7:0] acc_addr, acc_wdata, acc_rdata, wr_addr, wr_data, rdat;
  logic [6:0] own_slave_addr;
  logic [6:0] acc_slave_addr = 7'h18;
  logic [3:0] strap_pin = 4'h0;
  int         fail_count = 0, cmp_count = 0, cyc = 0;

  csso_host_model host (.clk(clk), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));
  csso_channel_select dut (.clk(clk), .rst_b(rst_b), .acc_slave_addr(acc_slave_addr), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .own_slave_addr(own_slave_addr), .shared_wr(shared_wr),
    .chan_a_wr(chan_a_wr), .chan_b_wr(chan_b_wr), .wr_addr(wr_addr), .wr_data(wr_data),
    .shared_rdata(SH), .chan_a_rdata(CA), .chan_b_rdata(CB), .chan_a_irq(ia), .chan_b_irq(ib),
    .chan_a_loss(la), .chan_b_loss(lb), .strap_pin(strap_pin), .signal_loss_or_irq_pin(pin));

  initial begin
    forever #12.5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_strap(input logic [3:0] s);
    logic [6:0] sa;
    sa = 7'h18 + {2'b00, s, 1'b0};
    @(posedge clk);
    rst_b          <= 1'b0;
    strap_pin      <= s;
    acc_slave_addr <= sa;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("own_slave_addr", {1'b0, sa}, {1'b0, own_slave_addr});
    host.rd(OFS_CHAN_SELECT, rdat, vld);
    chk("select_reset", 8'h00, rdat);
    host.rd(OFS_STRAP_OBS, rdat, vld);
    chk("strap_hidden", SH, rdat);
    host.wr(OFS_DIAG_CTRL, 8'h0A);
    host.rd(OFS_STRAP_OBS, rdat, vld);
    chk("strap_shown", {s, SH[3:0]}, rdat);
  endtask
  task automatic t_refuse();
    acc_slave_addr <= 7'h19;
    host.wr(OFS_CHAN_SELECT, 8'h04);
    chk("refused_pulses", 8'h00, {5'h00, shared_wr, chan_a_wr, chan_b_wr});
    acc_slave_addr <= 7'h18;
    host.rd(OFS_CHAN_SELECT, rdat, vld);
    chk("refused_select", 8'h00, rdat);
  endtask
  task automatic t_steer();
    logic [7:0] sels [8] = '{8'h00, 8'h04, 8'h05, 8'h0C, 8'h0D, 8'h0E, 8'h03, 8'h08};
    logic [7:0] v, e;
    logic       en, bc;
    foreach (sels[i]) begin
      v  = sels[i];
      en = v[SEL_CHAN_EN_BIT];
      bc = v[SEL_BROADCAST_BIT];
      host.wr(OFS_CHAN_SELECT, v);
      chk("select_shared_wr", 8'h01, {7'h00, shared_wr});
      host.wr(8'h10, 8'h5A);
      e = {5'h00, !en, en && (v[1:0] == 2'h0 || bc), en && (v[1:0] == 2'h1 || bc)};
      chk("write_pulses", e, {5'h00, shared_wr, chan_a_wr, chan_b_wr});
      chk("write_data", 8'h5A, wr_data);
      host.rd(8'h10, rdat, vld);
      e = !en ? SH : (v[1:0] == 2'h0 ? CA : (v[1:0] == 2'h1 ? CB : 8'h00));
      chk("read_data", e, rdat);
      chk("read_valid", 8'h01, {7'h00, vld});
      host.rd(OFS_CHAN_SELECT, rdat, vld);
      chk("select_readback", v, rdat);
    end
  endtask
  // Levels: loss A, loss B, irq A, irq B
  task automatic t_pin(input logic [7:0] sel, input logic [3:0] lvl, input logic exp);
    host.wr(OFS_CHAN_SELECT, sel);
    @(posedge clk);
    {la, lb, ia, ib} <= lvl;
    repeat (3) @(posedge clk);
    #1;
    chk("pin_level", {7'h00, exp}, {7'h00, pin});
    host.rd(OFS_IRQ_FLAGS, rdat, vld);
    chk("irq_flags", {SH[7:4], lvl[1:0], SH[1:0]}, rdat);
  endtask

  initial begin
    t_strap(4'h0);
    t_refuse();
    t_steer();
    t_pin(8'h00, 4'b1000, 1'b1);
    t_pin(8'h00, 4'b0011, 1'b0);
    t_pin(8'h20, 4'b1110, 1'b1);
    t_pin(8'h20, 4'b1100, 1'b0);
    t_pin(8'h20, 4'b0001, 1'b1);
    t_strap(4'h5);
    final_report();
  end
endmodule // channel_select_and_strap_observe_tb
